/* rtl/ksc_top.sv */
module ksc_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic osc_128k,
	input wire logic [63:0] key_closed_raw,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic key_event_irq_n,
	output logic key_event_irq_n_oe,
	output logic [5:0] matrix_column_outputs,
	output logic [5:0] matrix_column_outputs_oe,
	output logic matrix_sources_on
);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [63:0] key_s1_r, key_s2_r;
	logic osc_s1_r, osc_s2_r, osc_d_r;

	always_ff @(posedge clk) begin
		key_s1_r <= key_closed_raw;
		key_s2_r <= key_s1_r;
		osc_s1_r <= osc_128k;
		osc_s2_r <= osc_s1_r;
		osc_d_r <= osc_s2_r;
	end

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0] cfg_r, cfg_nxt, deb_r, deb_nxt, kint_r, kint_nxt;
	logic [7:0] ports_r, ports_nxt, rep_r, rep_nxt, slp_r, slp_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic half_r, half_nxt, tick;
	logic [6:0] tick_cnt_r, tick_cnt_nxt;
	logic ms_pulse;
	logic [5:0] per_cnt_r, per_cnt_nxt;
	logic period;
	logic [63:0] prev_r, prev_nxt, rep_keys_r, rep_keys_nxt;
	logic [5:0] stab_r, stab_nxt;
	logic [1:0] warm_r, warm_nxt;
	logic [7:0] rpt_cnt_r, rpt_cnt_nxt;
	logic rpt_first_r, rpt_first_nxt;
	logic [15:0] idle_r, idle_nxt;
	logic tim_act_r, tim_act_nxt;
	logic [4:0] tim_cnt_r, tim_cnt_nxt;
	logic irq_r, irq_nxt;
	logic irq_oe_r, irq_oe_nxt;
	logic [5:0] col_oe_r, col_oe_nxt;
	logic src_on_r, src_on_nxt;

	logic [5:0] deb_ms, col_en;
	logic [63:0] masked, diff;
	logic [5:0] diff_idx;
	logic settled, key_evt, rpt_push, push;
	logic [7:0] rpt_limit;
	ksc_pkg::ksc_entry_t push_data, head;
	logic pop, q_full, q_empty;
	logic [4:0] q_count;
	logic [2:0] gpo_code;
	logic [2:0] gpo_cols;
	logic awake, any_key;
	logic q_read;

	ksc_queue u_queue (
		.clk(clk),
		.reset(reset),
		.push(push),
		.push_data(push_data),
		.pop(pop),
		.head(head),
		.count(q_count),
		.full(q_full),
		.empty(q_empty)
	);

	// ----------------------------------------------------------------
	// Combinational decode
	// ----------------------------------------------------------------
	always_comb begin
		tick = osc_s2_r && !osc_d_r && half_r;
		ms_pulse = tick && (tick_cnt_r == ksc_pkg::TICKS_PER_MS_M1);
		deb_ms = {1'b0, deb_r[4:0]} + {1'b0, ksc_pkg::DEB_BASE_MS};
		period = ms_pulse && (per_cnt_r + 6'h01 >= deb_ms);
		gpo_code = deb_r[7:5];
		gpo_cols = 3'h0;
		if (gpo_code == 3'h0) begin
			gpo_cols = ksc_pkg::GPO_MAX_COLS;
		end else if (gpo_code != ksc_pkg::GPO_NONE_CODE) begin
			gpo_cols = ksc_pkg::GPO_NONE_CODE - gpo_code;
		end
		for (int c = 0; c < 6; c++) begin
			col_en[c] = (3'(c) < gpo_cols);
		end
		masked = key_s2_r;
		for (int c = 0; c < 6; c++) begin
			if (col_en[c]) begin
				masked[(c + 2) * 8 +: 8] = 8'h00;
			end
		end
		awake = cfg_r[ksc_pkg::CFG_AWAKE_BIT];
		any_key = |masked;
		settled = awake && (warm_r == 2'h0) && (stab_r >= deb_ms);
		diff = settled ? (masked ^ rep_keys_r) : 64'h0;
		diff_idx = 6'h00;
		for (int i = 63; i >= 0; i--) begin
			if (diff[i]) begin
				diff_idx = 6'(i);
			end
		end
		key_evt = |diff;
		push_data.key = diff_idx;
		push_data.rel = !masked[diff_idx];
		rpt_limit = rpt_first_r ? {rep_r[3:0], 3'h0} + 8'h08
			: {3'h0, rep_r[6:4], 2'h0} + 8'h04;
		rpt_push = !key_evt && rep_r[ksc_pkg::REP_EN_BIT] && (|rep_keys_r)
			&& period && (rpt_cnt_r + 8'h01 >= rpt_limit);
		if (rpt_push) begin
			push_data = ksc_pkg::ksc_entry_t'(ksc_pkg::CODE_REPEAT);
		end
		push = rpt_push || (key_evt && (masked[diff_idx]
			|| cfg_r[ksc_pkg::CFG_RELEASE_BIT]));
		q_read = reg_rd && (reg_addr == ksc_pkg::OFS_QUEUE);
		pop = q_read && !q_empty;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		cfg_nxt = cfg_r;
		deb_nxt = deb_r;
		kint_nxt = kint_r;
		ports_nxt = ports_r;
		rep_nxt = rep_r;
		slp_nxt = slp_r;
		half_nxt = (osc_s2_r && !osc_d_r) ? !half_r : half_r;
		tick_cnt_nxt = tick ? (ms_pulse ? 7'h00 : tick_cnt_r + 7'h01)
			: tick_cnt_r;
		per_cnt_nxt = period ? 6'h00 : (ms_pulse ? per_cnt_r + 6'h01
			: per_cnt_r);
		prev_nxt = masked;
		stab_nxt = stab_r;
		if (masked != prev_r || !awake || warm_r != 2'h0) begin
			stab_nxt = 6'h00;
		end else if (ms_pulse && stab_r != 6'h3f) begin
			stab_nxt = stab_r + 6'h01;
		end
		rep_keys_nxt = rep_keys_r;
		if (key_evt) begin
			rep_keys_nxt[diff_idx] = masked[diff_idx];
		end
		warm_nxt = (ms_pulse && warm_r != 2'h0) ? warm_r - 2'h1 : warm_r;
		rpt_cnt_nxt = period ? rpt_cnt_r + 8'h01 : rpt_cnt_r;
		rpt_first_nxt = rpt_first_r;
		if (key_evt) begin
			rpt_cnt_nxt = 8'h00;
			rpt_first_nxt = 1'b1;
		end else if (rpt_push) begin
			rpt_cnt_nxt = 8'h00;
			rpt_first_nxt = 1'b0;
		end
		idle_nxt = (any_key || key_evt || !awake) ? 16'h0000
			: (ms_pulse ? idle_r + 16'h0001 : idle_r);
		if (awake && slp_r[2:0] != 3'h0
			&& idle_r > 16'(slp_r[2:0] * ksc_pkg::SLEEP_STEP_MS)) begin
			cfg_nxt[ksc_pkg::CFG_AWAKE_BIT] = 1'b0;
		end
		if (!awake && cfg_r[ksc_pkg::CFG_AUTOWAKE_BIT] && any_key) begin
			cfg_nxt[ksc_pkg::CFG_AWAKE_BIT] = 1'b1;
			warm_nxt = ksc_pkg::WAKE_MS;
		end
		if (reg_wr) begin
			case (reg_addr)
				ksc_pkg::OFS_CFG: begin
					cfg_nxt = reg_wdata;
					if (!awake && reg_wdata[ksc_pkg::CFG_AWAKE_BIT]) begin
						warm_nxt = ksc_pkg::WAKE_MS;
					end
				end
				ksc_pkg::OFS_DEB: deb_nxt = reg_wdata;
				ksc_pkg::OFS_KINT: kint_nxt = reg_wdata;
				ksc_pkg::OFS_PORTS: ports_nxt = reg_wdata;
				ksc_pkg::OFS_REP: rep_nxt = reg_wdata;
				ksc_pkg::OFS_SLEEP: slp_nxt = reg_wdata;
				default: begin
				end
			endcase
		end
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				ksc_pkg::OFS_QUEUE: begin
					if (q_empty) begin
						rdata_nxt = ksc_pkg::CODE_EMPTY;
					end else if (head.key >= ksc_pkg::KEY_62) begin
						rdata_nxt = {1'b0, head};
					end else begin
						rdata_nxt = {q_count > 5'h01, head};
					end
				end
				ksc_pkg::OFS_CFG: rdata_nxt = cfg_r;
				ksc_pkg::OFS_DEB: rdata_nxt = deb_r;
				ksc_pkg::OFS_KINT: rdata_nxt = kint_r;
				ksc_pkg::OFS_PORTS: rdata_nxt = ports_r;
				ksc_pkg::OFS_REP: rdata_nxt = rep_r;
				ksc_pkg::OFS_SLEEP: rdata_nxt = slp_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		tim_act_nxt = tim_act_r;
		tim_cnt_nxt = tim_cnt_r;
		irq_nxt = irq_r;
		if (q_read && (!cfg_r[ksc_pkg::CFG_IRQ_POLICY_BIT]
			|| q_count <= 5'h01)) begin
			irq_nxt = 1'b0;
		end
		if (push) begin
			tim_act_nxt = 1'b1;
			tim_cnt_nxt = 5'h00;
		end else if (tim_act_r && period) begin
			tim_cnt_nxt = tim_cnt_r + 5'h01;
			if (kint_r[4:0] != 5'h00 && tim_cnt_r + 5'h01 >= kint_r[4:0]) begin
				irq_nxt = 1'b1;
				tim_act_nxt = 1'b0;
			end
		end
		if (kint_r[7:5] != 3'h0 && q_count >= {1'b0, kint_r[7:5], 1'b0}) begin
			irq_nxt = 1'b1;
		end
		if (kint_r == 8'h00) begin
			irq_oe_nxt = !ports_r[ksc_pkg::PORTS_IRQ_BIT];
		end else begin
			irq_oe_nxt = irq_nxt;
		end
		col_oe_nxt = col_en & ~ports_r[ksc_pkg::PORTS_COL_LSB +: 6];
		src_on_nxt = cfg_nxt[ksc_pkg::CFG_AWAKE_BIT];
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_r <= ksc_pkg::RST_CFG;
			deb_r <= ksc_pkg::RST_DEB;
			kint_r <= ksc_pkg::RST_KINT;
			ports_r <= ksc_pkg::RST_PORTS;
			rep_r <= ksc_pkg::RST_REP;
			slp_r <= ksc_pkg::RST_SLEEP;
			rdata_r <= 8'h00;
			half_r <= 1'b0;
			tick_cnt_r <= 7'h00;
			per_cnt_r <= 6'h00;
			prev_r <= 64'h0;
			rep_keys_r <= 64'h0;
			stab_r <= 6'h00;
			warm_r <= 2'h0;
			rpt_cnt_r <= 8'h00;
			rpt_first_r <= 1'b1;
			idle_r <= 16'h0000;
			tim_act_r <= 1'b0;
			tim_cnt_r <= 5'h00;
			irq_r <= 1'b0;
			irq_oe_r <= 1'b0;
			col_oe_r <= 6'h00;
			src_on_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			deb_r <= deb_nxt;
			kint_r <= kint_nxt;
			ports_r <= ports_nxt;
			rep_r <= rep_nxt;
			slp_r <= slp_nxt;
			rdata_r <= rdata_nxt;
			half_r <= half_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			per_cnt_r <= per_cnt_nxt;
			prev_r <= prev_nxt;
			rep_keys_r <= rep_keys_nxt;
			stab_r <= stab_nxt;
			warm_r <= warm_nxt;
			rpt_cnt_r <= rpt_cnt_nxt;
			rpt_first_r <= rpt_first_nxt;
			idle_r <= idle_nxt;
			tim_act_r <= tim_act_nxt;
			tim_cnt_r <= tim_cnt_nxt;
			irq_r <= irq_nxt;
			irq_oe_r <= irq_oe_nxt;
			col_oe_r <= col_oe_nxt;
			src_on_r <= src_on_nxt;
		end
	end

	// Open-drain pins only ever pull low; the enable carries the level.
	always_ff @(posedge clk) begin
		key_event_irq_n <= 1'b0;
		matrix_column_outputs <= 6'h00;
	end

	assign reg_rdata = rdata_r;
	assign key_event_irq_n_oe = irq_oe_r;
	assign matrix_column_outputs_oe = col_oe_r;
	assign matrix_sources_on = src_on_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence wake_req_s;
		!awake && cfg_r[ksc_pkg::CFG_AUTOWAKE_BIT] && any_key;
	endsequence

	sequence wake_done_s;
		awake && warm_r == ksc_pkg::WAKE_MS;
	endsequence

	empty_read_code_a: assert property (@(posedge clk) disable iff (reset)
		q_read && q_empty |=> reg_rdata == ksc_pkg::CODE_EMPTY)
		else $error("empty queue read did not return empty code");

	tick_spacing_a: assert property (@(posedge clk) disable iff (reset)
		tick |=> !tick [*8])
		else $error("tick pulses too close together");

	auto_wake_a: assert property (@(posedge clk) disable iff (reset)
		wake_req_s |=> wake_done_s ##1 matrix_sources_on)
		else $error("autowake did not start warmup");

	sleep_sources_a: assert property (@(posedge clk) disable iff (reset)
		!cfg_r[ksc_pkg::CFG_AWAKE_BIT] && !reg_wr
		&& !(cfg_r[ksc_pkg::CFG_AUTOWAKE_BIT] && any_key)
		|=> !matrix_sources_on)
		else $error("matrix sources on while asleep");

	gpo_irq_pin_a: assert property (@(posedge clk) disable iff (reset)
		kint_r == 8'h00
		|=> key_event_irq_n_oe == !$past(ports_r[ksc_pkg::PORTS_IRQ_BIT]))
		else $error("interrupt pin not following ports bit");

	level_irq_a: assert property (@(posedge clk) disable iff (reset)
		kint_r[7:5] != 3'h0 && q_count >= {1'b0, kint_r[7:5], 1'b0}
		|=> irq_r)
		else $error("queue level interrupt missing");

	repeat_entry_a: assert property (@(posedge clk) disable iff (reset)
		rpt_push |-> push && push_data == ksc_pkg::CODE_REPEAT && !key_evt)
		else $error("repeat entry malformed");

	settle_time_a: assert property (@(posedge clk) disable iff (reset)
		key_evt |-> stab_r >= deb_ms && warm_r == 2'h0 && awake)
		else $error("event queued before debounce settled");

	col_disabled_a: assert property (@(posedge clk) disable iff (reset)
		!col_en[0] ##1 !col_en[0] |-> !matrix_column_outputs_oe[0])
		else $error("column drives while not a general output");

	read_clear_a: assert property (@(posedge clk) disable iff (reset)
		q_read && !cfg_r[ksc_pkg::CFG_IRQ_POLICY_BIT] && !push
		&& !(kint_r[7:5] != 3'h0 && q_count >= {1'b0, kint_r[7:5], 1'b0})
		&& !(tim_act_r && period) |=> !irq_r)
		else $error("queue read did not clear interrupt");

endmodule

/* rtl/ksc_pkg.sv */
package ksc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_QUEUE = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h01;
	localparam logic [7:0] OFS_DEB = 8'h02;
	localparam logic [7:0] OFS_KINT = 8'h03;
	localparam logic [7:0] OFS_PORTS = 8'h04;
	localparam logic [7:0] OFS_REP = 8'h05;
	localparam logic [7:0] OFS_SLEEP = 8'h06;

	// ----------------------------------------------------------------
	// Power-up values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CFG = 8'h0a;
	localparam logic [7:0] RST_DEB = 8'hff;
	localparam logic [7:0] RST_KINT = 8'h00;
	localparam logic [7:0] RST_PORTS = 8'hfe;
	localparam logic [7:0] RST_REP = 8'h00;
	localparam logic [7:0] RST_SLEEP = 8'h07;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int CFG_AWAKE_BIT = 7;
	localparam int CFG_IRQ_POLICY_BIT = 5;
	localparam int CFG_RELEASE_BIT = 3;
	localparam int CFG_AUTOWAKE_BIT = 1;
	localparam int PORTS_IRQ_BIT = 1;
	localparam int PORTS_COL_LSB = 2;
	localparam int REP_EN_BIT = 7;
	localparam logic [7:0] CODE_EMPTY = 8'h3f;
	localparam logic [6:0] CODE_REPEAT = 7'h7e;
	localparam logic [5:0] KEY_62 = 6'h3e;
	localparam logic [4:0] DEB_BASE_MS = 5'h09;
	localparam logic [2:0] GPO_NONE_CODE = 3'h7;
	localparam logic [2:0] GPO_MAX_COLS = 3'h6;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int OSC_KHZ = 128;
	localparam int TICK_KHZ = 64;
	localparam int TICKS_PER_MS = TICK_KHZ;
	localparam logic [6:0] TICKS_PER_MS_M1 = 7'(TICKS_PER_MS - 1);
	localparam logic [1:0] WAKE_MS = 2'h2;
	localparam logic [15:0] SLEEP_STEP_MS = 16'h0200;

	// ----------------------------------------------------------------
	// Queue
	// ----------------------------------------------------------------
	localparam int QUEUE_DEPTH = 16;
	localparam int QUEUE_AW = 4;

	typedef struct packed {
		logic rel;
		logic [5:0] key;
	} ksc_entry_t;

endpackage

/* rtl/ksc_queue.sv */
module ksc_queue (
	input wire logic clk,
	input wire logic reset,
	input wire logic push,
	input ksc_pkg::ksc_entry_t push_data,
	input wire logic pop,
	output ksc_pkg::ksc_entry_t head,
	output logic [4:0] count,
	output logic full,
	output logic empty
);

	ksc_pkg::ksc_entry_t mem_r [ksc_pkg::QUEUE_DEPTH];
	logic [3:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic do_push, do_pop;

	assign full = (cnt_r == 5'(ksc_pkg::QUEUE_DEPTH));
	assign empty = (cnt_r == 5'h00);
	assign count = cnt_r;
	assign head = mem_r[rp_r];

	// Full queue drops new entries; stored ones are never overwritten.
	always_comb begin
		do_push = push && !full;
		do_pop = pop && !empty;
		wp_nxt = do_push ? wp_r + 4'h1 : wp_r;
		rp_nxt = do_pop ? rp_r + 4'h1 : rp_r;
		cnt_nxt = cnt_r;
		if (do_push && !do_pop) begin
			cnt_nxt = cnt_r + 5'h01;
		end else if (do_pop && !do_push) begin
			cnt_nxt = cnt_r - 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wp_r <= 4'h0;
			rp_r <= 4'h0;
			cnt_r <= 5'h00;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (do_push) begin
			mem_r[wp_r] <= push_data;
		end
	end

endmodule

/* dv/ksc_matrix_model.sv */
module ksc_matrix_model (
	input wire logic [63:0] keys,
	output logic osc_128k,
	output logic [63:0] key_closed_raw
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Oscillator
	// ----------------------------------------------------------------
	// The oscillator toggles every 80 ns, so its edges fall on system clock falling edges.
	initial osc_128k = 1'b0;
	always #80 osc_128k = ~osc_128k;

	// ----------------------------------------------------------------
	// Switch matrix
	// ----------------------------------------------------------------
	// Clean switches: a closed key reads 1, an open key reads 0.
	assign key_closed_raw = keys;
endmodule

/* dv/ksc_top_tb.sv */
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("[ERR] %0t: got %h expected %h", $time, got, exp); \
		end \
	end

module ksc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [63:0] keys = '0;
	logic osc_128k;
	logic [63:0] key_closed_raw;
	logic [7:0] reg_rdata;
	logic key_event_irq_n;
	logic key_event_irq_n_oe;
	logic [5:0] matrix_column_outputs;
	logic [5:0] matrix_column_outputs_oe;
	logic matrix_sources_on;
	int n_mismatch = 0;
	int check_count = 0;
	int n_cols;
	int wait_n;
	logic [7:0] rd;
	logic [5:0] gpo_mask;
	logic [7:0] rst_val [7] = '{8'h3f, 8'h0a, 8'hff, 8'h00, 8'hfe, 8'h00,
		8'h07};

	always #2 clk = ~clk;

	ksc_matrix_model ksc_matrix_model_inst (
		.keys(keys),
		.osc_128k(osc_128k),
		.key_closed_raw(key_closed_raw)
	);

	ksc_top ksc_top_inst (
		.clk(clk),
		.reset(reset),
		.osc_128k(osc_128k),
		.key_closed_raw(key_closed_raw),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.key_event_irq_n(key_event_irq_n),
		.key_event_irq_n_oe(key_event_irq_n_oe),
		.matrix_column_outputs(matrix_column_outputs),
		.matrix_column_outputs_oe(matrix_column_outputs_oe),
		.matrix_sources_on(matrix_sources_on)
	);

	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// Read data is registered, so it is taken one full cycle later.
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", check_count,
			n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		#360000;
		n_mismatch++;
		$display("[ERR] %0t: watchdog expired", $time);
		stop_test();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 7; i++) begin
			reg_read(8'(i), rd);
			`CHK(rd, rst_val[i])
		end
		`CHK(matrix_sources_on, 1'b0)
		reg_read(8'h07, rd);
		`CHK(rd, 8'h00)
		reg_write(8'h00, 8'h55);
		reg_read(8'h00, rd);
		`CHK(rd, 8'h3f)

		// General outputs: interrupt pin and every column code.
		reg_write(8'h04, 8'h00);
		wait_cycles(3);
		`CHK(key_event_irq_n_oe, 1'b1)
		`CHK(key_event_irq_n, 1'b0)
		reg_read(8'h04, rd);
		`CHK(rd, 8'h00)
		for (int c = 0; c < 8; c++) begin
			reg_write(8'h02, {3'(c), 5'h00});
			wait_cycles(3);
			n_cols = (c == 7) ? 0 : ((c == 0) ? 6 : 7 - c);
			gpo_mask = 6'((1 << n_cols) - 1);
			`CHK(matrix_column_outputs_oe, gpo_mask)
		end
		reg_write(8'h02, 8'ha0);
		reg_write(8'h04, 8'h08);
		wait_cycles(3);
		`CHK(matrix_column_outputs_oe, 6'h01)
		`CHK(matrix_column_outputs, 6'h00)
		reg_write(8'h02, 8'he0);
		reg_write(8'h03, 8'h20);
		wait_cycles(3);
		`CHK(key_event_irq_n_oe, 1'b0)

		// Wake, press three keys at once, level interrupt at two entries.
		reg_write(8'h01, 8'h8a);
		keys[5] = 1'b1;
		keys[62] = 1'b1;
		keys[63] = 1'b1;
		wait_n = 0;
		while (key_event_irq_n_oe !== 1'b1 && wait_n < 70000) begin
			@(negedge clk);
			wait_n++;
		end
		// A millisecond is 128 oscillator rising edges, 5120 clock cycles.
		`CHK(wait_n >= 9 * 5120 - 200, 1'b1)
		`CHK(wait_n <= 11 * 5120 + 200, 1'b1)
		`CHK(key_event_irq_n_oe, 1'b1)
		`CHK(matrix_sources_on, 1'b1)
		reg_read(8'h00, rd);
		`CHK(rd, 8'h85)
		// The level is still met at that read, so the set outweighs the clear.
		wait_cycles(2);
		`CHK(key_event_irq_n_oe, 1'b1)
		reg_read(8'h00, rd);
		`CHK(rd, 8'h3e)
		reg_read(8'h00, rd);
		`CHK(rd, 8'h3f)
		wait_cycles(2);
		`CHK(key_event_irq_n_oe, 1'b0)
		reg_read(8'h00, rd);
		`CHK(rd, 8'h3f)
		reg_read(8'h01, rd);
		`CHK(rd, 8'h8a)

		// Host puts the device to sleep with autowake disabled.
		reg_write(8'h01, 8'h08);
		wait_cycles(3);
		`CHK(matrix_sources_on, 1'b0)
		reg_read(8'h01, rd);
		`CHK(rd, 8'h08)

		// Enabling autowake while keys are held wakes the device at once.
		reg_write(8'h01, 8'h0a);
		wait_cycles(3);
		`CHK(matrix_sources_on, 1'b1)
		reg_read(8'h01, rd);
		`CHK(rd, 8'h8a)
		stop_test();
	end
endmodule
